// >>> core/asp_consts.svh
// constants for the async serial port with handshake
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_OVERSAMPLE 5'h10
`define ASP_OVS_MID 4'h7
`define ASP_OVS_LAST 4'hF
`define ASP_CTL_TXEN 0
`define ASP_CTL_RXEN 1
`define ASP_CTL_RXINIT 2
`define ASP_CTL_TXINIT 3
`define ASP_FMT_LEN_LO 0
`define ASP_FMT_PAR_LO 2
`define ASP_FMT_STOP 4
`define ASP_FMT_PRE_LO 5
`define ASP_LEN7 2'h0
`define ASP_LEN8 2'h1
`define ASP_LEN9 2'h2
`define ASP_BITS7 4'h7
`define ASP_BITS8 4'h8
`define ASP_BITS9 4'h9
`define ASP_PRE_LIM1 6'h00
`define ASP_PRE_LIM4 6'h03
`define ASP_PRE_LIM16 6'h0F
`define ASP_PRE_LIM64 6'h3F
`define ASP_PAR_NONE 2'h0
`define ASP_PAR_ODD 2'h1
`define ASP_PAR_EVEN 2'h2
`define ASP_ST_TXBUF_EMPTY 0
`define ASP_ST_TXSHIFT_EMPTY 1
`define ASP_ST_RXBUF_FULL 2
`define ASP_ST_OVERRUN 3
`define ASP_ST_FRAMING 4
`define ASP_ST_PARITY 5
`define ASP_ST_ERRSUM 6
`endif

// >>> core/asp_pkg.sv
// types shared by the async serial port
package asp_pkg;
	typedef enum logic [2:0] {
		ASP_IDLE = 3'h0,
		ASP_START = 3'h1,
		ASP_DATA = 3'h3,
		ASP_PARITY = 3'h2,
		ASP_STOP = 3'h6
	} asp_state_t;
endpackage

// >>> core/asp_tick_gen.sv
// prescaler and baud divider producing the 16x oversample tick
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_tick_gen #(
	parameter int DIV_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [1:0] pre_sel_i,
	input wire logic [DIV_W-1:0] divider_i,
	output logic tick_o
);
	// a zero-width divider cannot hold any ratio
	if (DIV_W < 1) begin : g_bad_width
		$error("DIV_W must be positive");
	end
	logic [5:0] pre_q;
	logic [DIV_W-1:0] div_q;
	logic pre_end;
	// prescaler ratio 1, 4, 16 or 64 chosen by two select bits
	function automatic logic [5:0] pre_limit(input logic [1:0] s);
		case (s)
			2'h0: pre_limit = `ASP_PRE_LIM1;
			2'h1: pre_limit = `ASP_PRE_LIM4;
			2'h2: pre_limit = `ASP_PRE_LIM16;
			default: pre_limit = `ASP_PRE_LIM64;
		endcase
	endfunction
	assign pre_end = (pre_q >= pre_limit(pre_sel_i));
	// prescaler stage; held clear when idle so the first tick has full length
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !run_i || pre_end) pre_q <= '0;
		else pre_q <= pre_q + 6'h01;
	end
	// divider counts n+1 prescaled pulses per 16x tick
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !run_i) begin
			div_q <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (pre_end) begin
				if (div_q >= divider_i) begin
					div_q <= '0;
					tick_o <= 1'b1;
				end else begin
					div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // asp_tick_gen

// >>> core/asp_top.sv
// async serial transmitter and receiver with rts/cts handshake
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_top #(
	parameter int DIV_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] serial_control_reg_i,
	input wire logic [6:0] serial_format_reg_i,
	input wire logic [DIV_W-1:0] baud_divider_reg_i,
	input wire logic [8:0] tx_data_i,
	input wire logic tx_write_i,
	input wire logic rx_read_i,
	output logic [8:0] rx_data_o,
	output logic [6:0] serial_status_reg_o,
	output logic tx_line_o,
	output logic request_to_send_out_o,
	output logic pins_serial_o,
	input wire logic rx_line_i,
	input wire logic clear_to_send_in_i
);
	logic tx_en, rx_en, rx_init, tx_init;
	logic [1:0] len_sel, par_sel, pre_sel;
	logic two_stop;
	logic tick;
	logic [3:0] data_bits;
	logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q;
	assign tx_en = serial_control_reg_i[`ASP_CTL_TXEN];
	assign rx_en = serial_control_reg_i[`ASP_CTL_RXEN];
	assign rx_init = serial_control_reg_i[`ASP_CTL_RXINIT];
	assign tx_init = serial_control_reg_i[`ASP_CTL_TXINIT];
	assign len_sel = serial_format_reg_i[`ASP_FMT_LEN_LO +: 2];
	assign par_sel = serial_format_reg_i[`ASP_FMT_PAR_LO +: 2];
	assign two_stop = serial_format_reg_i[`ASP_FMT_STOP];
	assign pre_sel = serial_format_reg_i[`ASP_FMT_PRE_LO +: 2];
	// data length decode; unused code falls back to eight bits
	assign data_bits = (len_sel == `ASP_LEN7) ? `ASP_BITS7 :
		(len_sel == `ASP_LEN9) ? `ASP_BITS9 : `ASP_BITS8;
	// port pins switch to serial use whenever either side is enabled
	assign pins_serial_o = tx_en | rx_en;
	// pin synchronisers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			cts_s1_q <= 1'b1;
			cts_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= rx_line_i;
			rx_s2_q <= rx_s1_q;
			cts_s1_q <= clear_to_send_in_i;
			cts_s2_q <= cts_s1_q;
		end
	end
	logic tx_busy;
	logic rx_busy;
	asp_tick_gen #(.DIV_W(DIV_W)) u_tick (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.run_i(tx_en | rx_en | tx_busy | rx_busy),
		.pre_sel_i(pre_sel),
		.divider_i(baud_divider_reg_i),
		.tick_o(tick)
	);
	// parity over the active data bits; odd mode inverts
	function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
		input logic [1:0] p);
		logic acc;
		acc = (p == `ASP_PAR_ODD);
		for (int i = 0; i < 9; i++) begin
			if (i < n) acc = acc ^ d[i];
		end
		par_of = acc;
	endfunction
	// transmit side
	asp_pkg::asp_state_t tx_st_q;
	logic [8:0] tx_buf_q, tx_sh_q;
	logic tx_full_q;
	logic [3:0] tx_ovs_q, tx_bit_q;
	logic tx_stop2_q;
	assign tx_busy = (tx_st_q != asp_pkg::ASP_IDLE);
	// transmit buffer: only software writes it, shifter loads from it
	always_ff @(posedge core_clk_i) begin
		if (rst_i || tx_init) begin
			tx_full_q <= 1'b0;
			tx_buf_q <= '0;
		end else if (tx_write_i) begin
			tx_full_q <= 1'b1;
			tx_buf_q <= tx_data_i;
		end else if (tx_st_q == asp_pkg::ASP_IDLE && tx_en && tx_full_q && !cts_s2_q
			&& tick) begin
			tx_full_q <= 1'b0;
		end
	end
	// transmit frame sequencer; once started it ignores enable and cts
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_st_q <= asp_pkg::ASP_IDLE;
			tx_sh_q <= '0;
			tx_ovs_q <= '0;
			tx_bit_q <= '0;
			tx_stop2_q <= 1'b0;
			tx_line_o <= 1'b1;
		end else begin
			case (tx_st_q)
				asp_pkg::ASP_IDLE: begin
					tx_line_o <= 1'b1;
					// start on a tick so the start bit lasts a whole bit time
					if (tx_en && tx_full_q && !cts_s2_q && !tx_write_i && tick) begin
						tx_sh_q <= tx_buf_q;
						tx_ovs_q <= '0;
						tx_bit_q <= '0;
						tx_stop2_q <= 1'b0;
						tx_line_o <= 1'b0;
						tx_st_q <= asp_pkg::ASP_START;
					end
				end
				default: begin
					if (tick) begin
						tx_ovs_q <= tx_ovs_q + 4'h1;
						if (tx_ovs_q == `ASP_OVS_LAST) begin
							case (tx_st_q)
								asp_pkg::ASP_START, asp_pkg::ASP_DATA: begin
									if (tx_st_q == asp_pkg::ASP_DATA)
										tx_bit_q <= tx_bit_q + 4'h1;
									if (tx_st_q == asp_pkg::ASP_DATA && tx_bit_q == data_bits - 4'h1) begin
										if (par_sel == `ASP_PAR_NONE) begin
											tx_st_q <= asp_pkg::ASP_STOP;
											tx_line_o <= 1'b1;
										end else begin
											tx_st_q <= asp_pkg::ASP_PARITY;
											tx_line_o <= par_of(tx_buf_q, data_bits, par_sel);
										end
									end else begin
										tx_st_q <= asp_pkg::ASP_DATA;
										tx_line_o <= tx_sh_q[0];
										tx_sh_q <= tx_sh_q >> 1;
									end
								end
								asp_pkg::ASP_PARITY: begin
									tx_st_q <= asp_pkg::ASP_STOP;
									tx_line_o <= 1'b1;
								end
								default: begin
									if (two_stop && !tx_stop2_q) tx_stop2_q <= 1'b1;
									else tx_st_q <= asp_pkg::ASP_IDLE;
									tx_line_o <= 1'b1;
								end
							endcase
						end
					end
				end
			endcase
		end
	end
	// receive side
	asp_pkg::asp_state_t rx_st_q;
	logic [8:0] rx_sh_q;
	logic [3:0] rx_ovs_q, rx_bit_q;
	logic rx_full_q, ovr_q, frm_q, par_q;
	logic rx_prev_q;
	logic rx_done;
	logic rx_start;
	logic rx_ferr;
	logic rx_perr;
	assign rx_busy = (rx_st_q != asp_pkg::ASP_IDLE);
	assign rx_start = rx_en && !rx_init && rx_st_q == asp_pkg::ASP_IDLE && rx_prev_q && !rx_s2_q;
	// receive frame sequencer sampling mid-bit on the 16x tick
	always_ff @(posedge core_clk_i) begin
		if (rst_i || rx_init) begin
			rx_st_q <= asp_pkg::ASP_IDLE;
			rx_sh_q <= '0;
			rx_ovs_q <= '0;
			rx_bit_q <= '0;
			rx_prev_q <= 1'b1;
			rx_done <= 1'b0;
			rx_ferr <= 1'b0;
			rx_perr <= 1'b0;
		end else begin
			rx_prev_q <= rx_s2_q;
			rx_done <= 1'b0;
			if (rx_start) begin
				rx_st_q <= asp_pkg::ASP_START;
				rx_ovs_q <= '0;
				rx_bit_q <= '0;
				rx_sh_q <= '0;
				rx_perr <= 1'b0;
			end else if (rx_busy && tick) begin
				rx_ovs_q <= rx_ovs_q + 4'h1;
				if (rx_ovs_q == `ASP_OVS_MID) begin
					rx_ovs_q <= rx_ovs_q + 4'h1;
					case (rx_st_q)
						asp_pkg::ASP_START: begin
							// a glitch that is high again mid-bit is not a start
							if (rx_s2_q) rx_st_q <= asp_pkg::ASP_IDLE;
							else rx_st_q <= asp_pkg::ASP_DATA;
						end
						asp_pkg::ASP_DATA: begin
							rx_sh_q[rx_bit_q] <= rx_s2_q;
							rx_bit_q <= rx_bit_q + 4'h1;
							if (rx_bit_q == data_bits - 4'h1)
								rx_st_q <= (par_sel == `ASP_PAR_NONE) ?
									asp_pkg::ASP_STOP : asp_pkg::ASP_PARITY;
						end
						asp_pkg::ASP_PARITY: begin
							rx_perr <= (rx_s2_q != par_of(rx_sh_q, data_bits, par_sel));
							rx_st_q <= asp_pkg::ASP_STOP;
						end
						default: begin
							// only the first stop bit is checked on receive
							rx_ferr <= !rx_s2_q;
							rx_done <= 1'b1;
							rx_st_q <= asp_pkg::ASP_IDLE;
						end
					endcase
				end
			end
		end
	end
	// receive buffer and error flags; new frame wins over a same-cycle read
	always_ff @(posedge core_clk_i) begin
		if (rst_i || rx_init) begin
			rx_full_q <= 1'b0;
			rx_data_o <= '0;
			ovr_q <= 1'b0;
			frm_q <= 1'b0;
			par_q <= 1'b0;
		end else if (rx_done) begin
			rx_full_q <= 1'b1;
			rx_data_o <= rx_sh_q;
			ovr_q <= rx_full_q && !rx_read_i;
			frm_q <= rx_ferr;
			par_q <= rx_perr;
		end else if (rx_read_i) begin
			rx_full_q <= 1'b0;
			ovr_q <= 1'b0;
			frm_q <= 1'b0;
			par_q <= 1'b0;
		end
	end
	// rts: reset and init force high, enable/start/done drive low
	logic rx_en_prev_q;
	always_ff @(posedge core_clk_i) begin
		if (rst_i || rx_init) begin
			request_to_send_out_o <= 1'b1;
			rx_en_prev_q <= 1'b0;
		end else begin
			rx_en_prev_q <= rx_en;
			if (rx_en && (!rx_en_prev_q || rx_done || rx_start))
				request_to_send_out_o <= 1'b0;
			else if (!rx_en && !rx_busy)
				request_to_send_out_o <= 1'b1;
		end
	end
	// status register outputs
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			serial_status_reg_o <= '0;
		end else begin
			serial_status_reg_o[`ASP_ST_TXBUF_EMPTY] <= !tx_full_q;
			serial_status_reg_o[`ASP_ST_TXSHIFT_EMPTY] <= !tx_busy;
			serial_status_reg_o[`ASP_ST_RXBUF_FULL] <= rx_full_q;
			serial_status_reg_o[`ASP_ST_OVERRUN] <= ovr_q;
			serial_status_reg_o[`ASP_ST_FRAMING] <= frm_q;
			serial_status_reg_o[`ASP_ST_PARITY] <= par_q;
			serial_status_reg_o[`ASP_ST_ERRSUM] <= ovr_q | frm_q | par_q;
		end
	end
endmodule // asp_top

// >>> test/asp_top_chk.sv
// port-level assertions for the async serial port
`timescale 1ns/1ps
module asp_top_chk #(
	parameter int DIV_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] serial_control_reg_i,
	input wire logic [6:0] serial_format_reg_i,
	input wire logic [DIV_W-1:0] baud_divider_reg_i,
	input wire logic [6:0] serial_status_reg_o,
	input wire logic tx_line_o,
	input wire logic request_to_send_out_o,
	input wire logic pins_serial_o,
	input wire logic clear_to_send_in_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [19:0] low_q;
	logic [19:0] bit_len;
	// length of a low run; a short start bit shows a divider slip
	always_ff @(posedge core_clk_i) begin
		if (tx_line_o) low_q <= 20'h0_0000;
		else low_q <= low_q + 20'h0_0001;
	end
	// clocks per bit, only valid while format and divider stand still
	assign bit_len = (20'h0_0010 << (2 * serial_format_reg_i[6:5]))
		* (20'(baud_divider_reg_i) + 20'h0_0001);
	a_reset_idle_pins: assert property (disable iff (1'b0)
		rst_i |=> request_to_send_out_o && tx_line_o)
		else $error("lines not high after reset");
	a_rxen_rts_low: assert property ($rose(serial_control_reg_i[1])
		&& !serial_control_reg_i[2] |=> !request_to_send_out_o)
		else $error("rts not low after rx enable");
	a_rxinit_rts_high: assert property (serial_control_reg_i[2]
		|=> request_to_send_out_o)
		else $error("rts not high after rx init");
	a_cts_blocks_start: assert property ((serial_status_reg_o[1]
		&& clear_to_send_in_i) [*4] |=> tx_line_o)
		else $error("frame started without cts");
	a_start_bit_len: assert property ($rose(tx_line_o) |-> low_q >= bit_len)
		else $error("low bit shorter than bit time");
	a_done_rts_low: assert property ($rose(serial_status_reg_o[2])
		&& serial_control_reg_i[1] |-> !request_to_send_out_o)
		else $error("rts high at reception done");
	a_err_summary: assert property (serial_status_reg_o[6]
		== |serial_status_reg_o[5:3])
		else $error("error summary bit wrong");
	a_pins_follow_en: assert property (pins_serial_o
		== (serial_control_reg_i[0] | serial_control_reg_i[1]))
		else $error("pin claim does not follow enables");
	c_tx_start: cover property ($fell(tx_line_o));
	c_rx_done: cover property ($rose(serial_status_reg_o[2]));
	c_rx_error: cover property ($rose(serial_status_reg_o[6]));
	c_overrun: cover property ($rose(serial_status_reg_o[3]));
endmodule // asp_top_chk

bind asp_top asp_top_chk #(.DIV_W(DIV_W)) u_chk (
	.core_clk_i(core_clk_i),
	.rst_i(rst_i),
	.serial_control_reg_i(serial_control_reg_i),
	.serial_format_reg_i(serial_format_reg_i),
	.baud_divider_reg_i(baud_divider_reg_i),
	.serial_status_reg_o(serial_status_reg_o),
	.tx_line_o(tx_line_o),
	.request_to_send_out_o(request_to_send_out_o),
	.pins_serial_o(pins_serial_o),
	.clear_to_send_in_i(clear_to_send_in_i)
);

// >>> test/asp_far_end.sv
// remote serial station: sends frames in and captures frames out
`timescale 1ns/1ps
module asp_far_end (
	input wire logic clk_i,
	input wire logic line_in_i,
	input wire logic rts_i,
	output logic line_out_o,
	output logic cts_o
);
	int bt = 16;
	// idle high; handshake closed until the bench opens it
	initial begin
		line_out_o = 1'b1;
		cts_o = 1'b1;
	end
	// handshake level; only this model drives its own outputs
	task automatic set_cts(input logic v);
		@(negedge clk_i);
		cts_o = v;
	endtask
	// clocks per bit on the line
	task automatic set_bit_len(input int b);
		bt = b;
	endtask
	// f[0] is the start bit; waits for rts low, which stays low after a frame, so it can still overrun the port
	task automatic send(input logic [12:0] f, input int n);
		wait (!rts_i);
		// rts moves on the rising edge; launch off the falling edge
		@(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_out_o = f[i];
			repeat (bt) @(negedge clk_i);
		end
		line_out_o = 1'b1;
	endtask
	// mid-bit sampling from the start edge
	task automatic grab(output logic [12:0] f, input int n);
		f = '0;
		@(negedge line_in_i);
		repeat (bt / 2) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			f[i] = line_in_i;
			repeat (bt) @(negedge clk_i);
		end
	endtask
endmodule // asp_far_end

// >>> test/test_asp_top.sv
// self-checking bench for the async serial port
`timescale 1ns/1ps
module test_asp_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ctl = 4'h0;
	logic [6:0] fmt = 7'h01;
	logic [7:0] div = 8'h00;
	logic [8:0] txd = 9'h000;
	logic txw = 1'b0;
	logic rxr = 1'b0;
	logic [8:0] rxd;
	logic [6:0] st;
	logic txl, rts, pins, rxl, cts;
	int fails = 0;
	int samples_checked = 0;
	asp_top dut (.core_clk_i(clk), .rst_i(rst), .serial_control_reg_i(ctl),
		.serial_format_reg_i(fmt), .baud_divider_reg_i(div), .tx_data_i(txd),
		.tx_write_i(txw), .rx_read_i(rxr), .rx_data_o(rxd),
		.serial_status_reg_o(st), .tx_line_o(txl), .request_to_send_out_o(rts),
		.pins_serial_o(pins), .rx_line_i(rxl), .clear_to_send_in_i(cts));
	asp_far_end far (.clk_i(clk), .line_in_i(txl), .rts_i(rts), .line_out_o(rxl),
		.cts_o(cts));
	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [12:0] g, input logic [12:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// expected frame: start, data lsb first, parity, stop bits all ones
	function automatic logic [12:0] mk(input logic [8:0] d, input int len, input int pc);
		logic [12:0] f;
		logic p;
		f = '1;
		f[0] = 1'b0;
		p = (pc == 1);
		for (int i = 0; i < len; i++) begin
			f[i+1] = d[i];
			p ^= d[i];
		end
		if (pc != 0) f[len+1] = p;
		return f;
	endfunction
	// one word out and one in; bit bad of the incoming frame is flipped
	task automatic xfer(input int lc, pc, sc, bad, input logic [8:0] d, input logic [3:0] ee);
		logic [12:0] f;
		logic [12:0] g;
		int len;
		int n;
		len = 7 + lc;
		n = 2 + len + (pc != 0) + sc;
		f = mk(d, len, pc);
		fmt[4:0] = 5'(sc * 16 + pc * 4 + lc);
		txd = d;
		txw = 1'b1;
		@(negedge clk);
		txw = 1'b0;
		far.grab(g, n);
		chk(g, f & 13'((1 << n) - 1));
		if (bad > 0) f[bad] = ~f[bad];
		far.send(f, n);
		for (int k = 0; k < 50 && st[2] !== 1'b1; k++) @(negedge clk);
		chk(st[2], 1'b1);
		chk(rxd, d & 9'((1 << len) - 1));
		chk(st[6:3], ee);
		rxr = 1'b1;
		@(negedge clk);
		rxr = 1'b0;
		@(negedge clk);
		chk(st[6:2], 5'h00);
	endtask
	task automatic t_reset;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk(rts, 1'b1);
		chk(txl, 1'b1);
		chk(st, 7'h03);
		chk(pins, 1'b0);
		$display("reset test done");
	endtask
	task automatic t_rts;
		ctl = 4'h2;
		@(negedge clk);
		chk(rts, 1'b0);
		chk(pins, 1'b1);
		ctl = 4'h6;
		repeat (2) @(negedge clk);
		chk(rts, 1'b1);
		ctl = 4'h2;
		@(negedge clk);
		ctl = 4'h0;
		repeat (2) @(negedge clk);
		chk(rts, 1'b1);
		// tx init empties a word that waits with transmit disabled
		txd = 9'h155;
		txw = 1'b1;
		@(negedge clk);
		txw = 1'b0;
		@(negedge clk);
		chk(st[0], 1'b0);
		ctl = 4'h8;
		repeat (2) @(negedge clk);
		chk(st[0], 1'b1);
		ctl = 4'h0;
		@(negedge clk);
		$display("rts test done");
	endtask
	// a pending word waits for cts, then finishes after cts and enable drop
	task automatic t_cts;
		logic [12:0] g;
		ctl = 4'h1;
		txd = 9'h0a5;
		txw = 1'b1;
		@(negedge clk);
		txw = 1'b0;
		repeat (80) @(negedge clk);
		chk(txl, 1'b1);
		chk(st[1:0], 2'h2);
		fork
			far.grab(g, 10);
			begin
				far.set_cts(1'b0);
				repeat (40) @(negedge clk);
				far.set_cts(1'b1);
				ctl = 4'h0;
			end
		join
		chk(g, mk(9'h0a5, 8, 0) & 13'h03ff);
		chk(st[1:0], 2'h3);
		far.set_cts(1'b0);
		ctl = 4'h3;
		$display("cts test done");
	endtask
	task automatic t_formats;
		for (int l = 0; l < 3; l++) begin
			for (int p = 0; p < 3; p++) begin
				for (int s = 0; s < 2; s++) begin
					xfer(l, p, s, 0, 9'h1a5 ^ 9'(l * 3 + p), 4'h0);
				end
			end
		end
		xfer(1, 2, 0, 9, 9'h05c, 4'hc);
		xfer(1, 0, 0, 9, 9'h0f3, 4'ha);
		$display("format test done");
	endtask
	// divider is loaded while both enables are off
	task automatic t_baud;
		ctl = 4'h0;
		fmt[6:5] = 2'h1;
		div = 8'h01;
		far.set_bit_len(128);
		@(negedge clk);
		ctl = 4'h3;
		xfer(1, 0, 0, 0, 9'h0c3, 4'h0);
		$display("bit rate test done");
	endtask
	// two frames with no read between them: second word kept, overrun flagged
	task automatic t_overrun;
		far.send(mk(9'h03c, 8, 0), 10);
		far.send(mk(9'h0e1, 8, 0), 10);
		repeat (2) @(negedge clk);
		chk(st[6:2], 5'h13);
		chk(rxd, 9'h0e1);
		rxr = 1'b1;
		@(negedge clk);
		rxr = 1'b0;
		@(negedge clk);
		chk(st[6:2], 5'h00);
		$display("overrun test done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		t_reset();
		t_rts();
		t_cts();
		t_formats();
		t_baud();
		t_overrun();
		complete_run();
	end
	// the tests need about 65 us; this cuts a hang well beyond that
	initial begin
		#300000;
		fails++;
		complete_run();
	end
endmodule // test_asp_top
